// File: nbmc_pkg.sv
package nbmc_pkg;

  // Address widths: nibble address in, byte address out
  localparam int NIB_AW  = 20;
  localparam int BYTE_AW = 19;

  // Configuration targets carried by a configuration command
  localparam logic [2:0] CFG_CTRL  = 3'h0;
  localparam logic [2:0] CFG_EXTRA = 3'h1;
  localparam logic [2:0] CFG_CARD1 = 3'h2;
  localparam logic [2:0] CFG_CARD2 = 3'h3;
  localparam logic [2:0] CFG_RAM   = 3'h4;

  // Device select codes; soft selects 0..3 are also config slot indices
  localparam logic [2:0] SEL_EXTRA = 3'h0;
  localparam logic [2:0] SEL_CARD1 = 3'h1;
  localparam logic [2:0] SEL_CARD2 = 3'h2;
  localparam logic [2:0] SEL_RAM   = 3'h3;
  localparam logic [2:0] SEL_ROM   = 3'h4;
  localparam int         NUM_SOFT  = 4;

  // Smallest window is 4K nibbles, so the low twelve mask bits never compare
  localparam logic [19:0] MASK_KEEP     = 20'hFF000;
  // Control window is 64 nibbles
  localparam logic [19:0] CTRL_WIN_MASK = 20'hFFFC0;

  // Control window offsets (nibbles) and fields
  localparam logic [5:0] OFF_CARD_CTL  = 6'h0E;
  localparam logic [5:0] OFF_CARD_STAT = 6'h0F;
  localparam logic [5:0] OFF_LINE_LO   = 6'h28;
  localparam logic [5:0] OFF_LINE_HI   = 6'h29;
  localparam int         ADDR_EXTEND_ENABLE_BIT      = 3;
  localparam int         M32_BIT       = 2;
  localparam logic [3:0] CARD_CTL_RST  = 4'h0;
  localparam logic [5:0] LINE_CNT_RST  = 6'h00;

  // Synchroniser vector layout
  localparam int SY_SENSE = 0;
  localparam int SY_DATA  = 9;
  localparam int SY_ON    = 17;
  localparam int SY_CWE   = 18;
  localparam int SY_CDET  = 20;
  localparam int SY_PWR   = 22;
  localparam int SY_W     = 23;
  localparam int SYNC_LAG = 4;

  // Timing
  localparam int CLK_NS        = 10;
  localparam int MEM_RD_NS     = 150;
  localparam int MEM_WR_NS     = 100;
  localparam int KEY_SETTLE_NS = 2000;
  localparam logic [7:0] RD_CYC  = 8'((MEM_RD_NS + CLK_NS - 1) / CLK_NS + SYNC_LAG);
  localparam logic [7:0] WR_CYC  = 8'((MEM_WR_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] KEY_CYC = 8'((KEY_SETTLE_NS + CLK_NS - 1) / CLK_NS + SYNC_LAG);

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_READ  = 3'b001,
    ST_WRITE = 3'b010,
    ST_HOLD  = 3'b011,
    ST_POLL  = 3'b100
  } state_e;

endpackage : nbmc_pkg

// File: nibble_bus_memory_controller.sv
`timescale 1ns/1ps
module nibble_bus_memory_controller
  import nbmc_pkg::*;
(
  input  wire logic              i_clk,
  input  wire logic              i_rst,
  input  wire logic              i_bus_reset,
  input  wire logic              i_cfg_valid,
  input  wire logic [2:0]        i_cfg_id,
  input  wire logic [19:0]       i_cfg_data,
  input  wire logic              i_req,
  input  wire logic              i_we,
  input  wire logic [19:0]       i_addr,
  input  wire logic [3:0]        i_wdata,
  output logic                   o_ack,
  output logic [3:0]             o_rdata,
  output logic                   o_wait,
  input  wire logic              i_rom_redirect_debug_mode,
  output logic                   o_ext_select,
  output logic                   o_ext_we,
  output logic [19:0]            o_ext_addr,
  output logic [3:0]             o_ext_wdata,
  input  wire logic [3:0]        i_ext_nibble,
  input  wire logic              i_timer_bit2,
  input  wire logic              i_in_reg_read,
  input  wire logic              i_out_reg_we,
  input  wire logic [11:0]       i_out_reg_data,
  output logic [8:0]             o_key_sense_lines,
  output logic                   o_beeper_pad,
  input  wire logic              i_on_key_line,
  output logic                   o_on_key_nmi,
  output logic                   o_wake_request,
  input  wire logic [1:0]        i_card_write_ok,
  input  wire logic [1:0]        i_card_detect,
  input  wire logic              i_card_power_rail,
  output logic [17:0]            o_mem_byte_addr,
  output logic [17:0]            o_mem_byte_addr_oe,
  input  wire logic [8:0]        i_key_sense_lines,
  output logic [7:0]             o_mem_byte_lines,
  output logic                   o_mem_byte_lines_oe,
  input  wire logic [7:0]        i_mem_byte_lines,
  output logic                   o_boot_rom_select_n,
  output logic                   o_ram_select_n,
  output logic                   o_extra_select_n,
  output logic                   o_card1_select,
  output logic                   o_card2_select,
  output logic                   o_write_strobe_n
);

  typedef struct packed {
    state_e                        state;
    logic [7:0]                    cnt;
    logic                          ack;
    logic [3:0]                    rdata;
    logic [NUM_SOFT-1:0][19:0]     mask;
    logic [NUM_SOFT-1:0][19:0]     base;
    logic [NUM_SOFT-1:0]           have_mask;
    logic [NUM_SOFT-1:0]           cfgd;
    logic [19:0]                   ctrl_base;
    logic                          ctrl_cfgd;
    logic [19:0]                   addr;
    logic                          we;
    logic [3:0]                    wdata;
    logic [2:0]                    sel;
    logic                          buf_valid;
    logic [2:0]                    buf_sel;
    logic [18:0]                   buf_addr;
    logic [7:0]                    buf_data;
    logic                          ext_sel;
    logic [3:0]                    card_ctl;
    logic [5:0]                    line_cnt;
    logic                          m32;
    logic                          addr_extend_enable;
    logic                          tmr_prev;
    logic                          poll_pend;
    logic [8:0]                    out_pend;
    logic [8:0]                    key_drive;
    logic [8:0]                    key_sense;
    logic                          beeper;
    logic                          on_prev;
    logic                          nmi;
    logic [SY_W-1:0]               s1;
    logic [SY_W-1:0]               s2;
    logic [SY_W-1:0]               s3;
    logic [SY_W-1:0]               filt;
  } ctl_s;

  ctl_s q;
  ctl_s n;

  logic [SY_W-1:0]     pins;
  logic [SY_W-1:0]     filt_next;
  logic [NUM_SOFT-1:0] soft_hit;
  logic                ctrl_hit;
  logic [2:0]          pick;
  logic                pwr;
  logic                mem_busy;
  logic                polling;
  logic [18:0]         req_byte;

  assign pins = {i_card_power_rail, i_card_detect, i_card_write_ok, i_on_key_line,
                 i_mem_byte_lines, i_key_sense_lines};

  // Take a new value only once the second and third stages agree
  genvar gi;
  generate
    for (gi = 0; gi < SY_W; gi++) begin : g_filt
      assign filt_next[gi] = (q.s2[gi] == q.s3[gi]) ? q.s3[gi] : q.filt[gi];
    end
    for (gi = 0; gi < NUM_SOFT; gi++) begin : g_hit
      assign soft_hit[gi] = q.cfgd[gi] && (((i_addr ^ q.base[gi]) & q.mask[gi]) == 20'h00000);
    end
  endgenerate

  assign ctrl_hit = q.ctrl_cfgd && (((i_addr ^ q.ctrl_base) & CTRL_WIN_MASK) == 20'h00000);

  always_comb begin
    if (soft_hit[SEL_RAM[1:0]]) begin
      pick = SEL_RAM;
    end else if (soft_hit[SEL_CARD2[1:0]]) begin
      pick = SEL_CARD2;
    end else if (soft_hit[SEL_CARD1[1:0]]) begin
      pick = SEL_CARD1;
    end else if (soft_hit[SEL_EXTRA[1:0]]) begin
      pick = SEL_EXTRA;
    end else begin
      pick = SEL_ROM;
    end
  end

  assign req_byte = i_addr[19:1];

  always_comb begin
    n         = q;
    n.ack     = 1'b0;
    n.ext_sel = 1'b0;
    n.nmi     = 1'b0;
    n.s1      = pins;
    n.s2      = q.s1;
    n.s3      = q.s2;
    n.filt    = filt_next;

    // poll tick from timer bit 2
    n.tmr_prev = i_timer_bit2;
    if ((i_timer_bit2 && !q.tmr_prev) || i_in_reg_read) begin
      n.poll_pend = 1'b1;
    end

    if (i_out_reg_we) begin
      n.out_pend = i_out_reg_data[8:0];
      n.beeper   = i_out_reg_data[11];
    end

    n.on_prev = q.filt[SY_ON];
    if (q.filt[SY_ON] && !q.on_prev) begin
      n.nmi = 1'b1;
    end

    if (i_cfg_valid) begin
      if (i_cfg_id == CFG_CTRL) begin
        n.ctrl_base = i_cfg_data;
        n.ctrl_cfgd = 1'b1;
      end else if (i_cfg_id <= CFG_RAM) begin
        if (!q.have_mask[2'(i_cfg_id - 3'h1)]) begin
          n.mask[2'(i_cfg_id - 3'h1)]      = i_cfg_data & MASK_KEEP;
          n.have_mask[2'(i_cfg_id - 3'h1)] = 1'b1;
        end else begin
          n.base[2'(i_cfg_id - 3'h1)]      = i_cfg_data;
          n.cfgd[2'(i_cfg_id - 3'h1)]      = 1'b1;
          n.have_mask[2'(i_cfg_id - 3'h1)] = 1'b0;
        end
      end
      // Stale byte may belong to a device that just moved
      n.buf_valid = 1'b0;
    end

    if (i_bus_reset) begin
      n.cfgd      = '0;
      n.have_mask = '0;
      n.ctrl_cfgd = 1'b0;
      n.buf_valid = 1'b0;
    end

    unique case (q.state)
      ST_IDLE: begin
        // memory request ahead of key poll
        if (i_req && !q.ack) begin
          n.addr  = i_addr;
          n.we    = i_we;
          n.wdata = i_wdata;
          n.sel   = pick;
          if (ctrl_hit) begin
            n.ack   = 1'b1;
            n.rdata = 4'h0;
            if (i_we) begin
              if (i_addr[5:0] == OFF_CARD_CTL) begin
                n.card_ctl = i_wdata;
              end else if (i_addr[5:0] == OFF_LINE_LO) begin
                n.line_cnt[3:0] = i_wdata;
              end else if (i_addr[5:0] == OFF_LINE_HI) begin
                n.line_cnt[5:4] = i_wdata[1:0];
                n.m32           = i_wdata[M32_BIT];
                n.addr_extend_enable          = i_wdata[ADDR_EXTEND_ENABLE_BIT];
              end
            end else begin
              if (i_addr[5:0] == OFF_CARD_CTL) begin
                n.rdata = q.card_ctl;
              end else if (i_addr[5:0] == OFF_CARD_STAT) begin
                n.rdata = {q.filt[SY_CWE +: 2], q.filt[SY_CDET +: 2]};
              end else if (i_addr[5:0] == OFF_LINE_LO) begin
                n.rdata = q.line_cnt[3:0];
              end else if (i_addr[5:0] == OFF_LINE_HI) begin
                n.rdata = {q.addr_extend_enable, q.m32, q.line_cnt[5:4]};
              end
            end
          end else if ((pick == SEL_EXTRA && q.addr_extend_enable) ||
                       (pick == SEL_ROM && i_rom_redirect_debug_mode)) begin
            n.ext_sel = 1'b1;
            n.ack     = 1'b1;
            n.rdata   = i_ext_nibble;
          end else if (i_we && ((pick == SEL_ROM) ||
                       (pick == SEL_CARD1 && !q.filt[SY_CWE]) ||
                       (pick == SEL_CARD2 && !q.filt[SY_CWE + 1]))) begin
            n.ack = 1'b1;
          end else if (q.buf_valid && q.buf_sel == pick && q.buf_addr == req_byte) begin
            if (i_we) begin
              if (i_addr[0]) begin
                n.buf_data[7:4] = i_wdata;
              end else begin
                n.buf_data[3:0] = i_wdata;
              end
              n.state = ST_WRITE;
              n.cnt   = WR_CYC;
            end else begin
              n.ack   = 1'b1;
              n.rdata = i_addr[0] ? q.buf_data[7:4] : q.buf_data[3:0];
            end
          end else begin
            n.buf_valid = 1'b0;
            n.buf_sel   = pick;
            n.buf_addr  = req_byte;
            n.state     = ST_READ;
            n.cnt       = RD_CYC;
          end
        end else if (q.poll_pend) begin
          // A trigger arriving in this same cycle must not be lost
          n.poll_pend = (i_timer_bit2 && !q.tmr_prev) || i_in_reg_read;
          n.key_drive = q.out_pend;
          n.state     = ST_POLL;
          n.cnt       = KEY_CYC;
        end
      end
      ST_READ: begin
        n.cnt = q.cnt - 8'h01;
        if (q.cnt == 8'h00) begin
          n.buf_data  = q.filt[SY_DATA +: 8];
          n.buf_valid = 1'b1;
          if (q.we) begin
            if (q.addr[0]) begin
              n.buf_data[7:4] = q.wdata;
            end else begin
              n.buf_data[3:0] = q.wdata;
            end
            n.state = ST_WRITE;
            n.cnt   = WR_CYC;
          end else begin
            n.ack   = 1'b1;
            n.rdata = q.addr[0] ? q.filt[SY_DATA + 4 +: 4] : q.filt[SY_DATA +: 4];
            n.state = ST_IDLE;
          end
        end
      end
      ST_WRITE: begin
        n.cnt = q.cnt - 8'h01;
        if (q.cnt == 8'h00) begin
          n.state = ST_HOLD;
        end
      end
      ST_HOLD: begin
        // Data held one cycle past strobe release
        n.ack   = 1'b1;
        n.state = ST_IDLE;
      end
      ST_POLL: begin
        n.cnt = q.cnt - 8'h01;
        if (q.cnt == 8'h00) begin
          n.key_sense = q.filt[SY_SENSE +: 9];
          n.state     = ST_IDLE;
        end
      end
      default: begin
        n.state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      q          <= '0;
      q.card_ctl <= CARD_CTL_RST;
      q.line_cnt <= LINE_CNT_RST;
    end else begin
      q <= n;
    end
  end

  assign pwr      = q.filt[SY_PWR];
  assign mem_busy = (q.state == ST_READ) || (q.state == ST_WRITE) || (q.state == ST_HOLD);
  assign polling  = (q.state == ST_POLL);

  // wait through polls and memory cycles
  assign o_wait       = q.state != ST_IDLE;
  assign o_ack        = q.ack;
  assign o_rdata      = q.rdata;
  assign o_ext_select = q.ext_sel;
  assign o_ext_we     = q.we;
  assign o_ext_addr   = q.addr;
  assign o_ext_wdata  = q.wdata;

  assign o_key_sense_lines = q.key_sense;
  assign o_beeper_pad      = q.beeper;
  assign o_on_key_nmi      = q.nmi;
  assign o_wake_request    = q.nmi;

  always_comb begin
    if (!pwr) begin
      o_mem_byte_addr    = 18'h00000;
      o_mem_byte_addr_oe = 18'h3FFFF;
    end else if (polling) begin
      o_mem_byte_addr    = {q.key_drive, 9'h000};
      o_mem_byte_addr_oe = {9'h1FF, 9'h000};
    end else begin
      o_mem_byte_addr    = q.buf_addr[17:0];
      o_mem_byte_addr_oe = 18'h3FFFF;
    end
  end

  assign o_mem_byte_lines    = pwr ? q.buf_data : 8'h00;
  assign o_mem_byte_lines_oe = !pwr || (q.state == ST_WRITE) || (q.state == ST_HOLD);
  assign o_write_strobe_n    = pwr && (q.state != ST_WRITE);
  assign o_boot_rom_select_n = pwr && !(mem_busy && q.buf_sel == SEL_ROM);
  assign o_ram_select_n      = pwr && !(mem_busy && q.buf_sel == SEL_RAM);
  assign o_card1_select      = pwr && mem_busy && q.buf_sel == SEL_CARD1;
  assign o_card2_select      = pwr && mem_busy && q.buf_sel == SEL_CARD2;
  // extension turns pin into inverted bit 18
  assign o_extra_select_n    = pwr && (q.addr_extend_enable ? !q.buf_addr[18] :
                                       !(mem_busy && q.buf_sel == SEL_EXTRA));

endmodule : nibble_bus_memory_controller

// File: nbmc_checker_properties.sv
`timescale 1ns/1ps
module nbmc_checker (
  input wire logic        i_clk,
  input wire logic        i_rst,
  input wire logic        i_req,
  input wire logic        i_in_reg_read,
  input wire logic        i_out_reg_we,
  input wire logic [11:0] i_out_reg_data,
  input wire logic        i_card_power_rail,
  input wire logic        o_ack,
  input wire logic        o_wait,
  input wire logic        o_beeper_pad,
  input wire logic        o_on_key_nmi,
  input wire logic        o_wake_request,
  input wire logic [17:0] o_mem_byte_addr,
  input wire logic [17:0] o_mem_byte_addr_oe,
  input wire logic [7:0]  o_mem_byte_lines,
  input wire logic        o_mem_byte_lines_oe,
  input wire logic        o_boot_rom_select_n,
  input wire logic        o_ram_select_n,
  input wire logic        o_card1_select,
  input wire logic        o_card2_select,
  input wire logic        o_write_strobe_n
);
  // Power passes a synchroniser, so only settled states are judged
  logic [3:0] on_q;
  logic [3:0] off_q;
  logic       powered;
  logic       poll;
  always_ff @(posedge i_clk) begin
    if (i_rst || !i_card_power_rail) on_q <= 4'h0;
    else if (on_q != 4'hF) on_q <= on_q + 4'h1;
    if (i_card_power_rail) off_q <= 4'h0;
    else if (off_q != 4'hF) off_q <= off_q + 4'h1;
  end
  assign powered = (on_q >= 4'h8);
  assign poll    = powered && (o_mem_byte_addr_oe[8:0] == 9'h000);

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  property p_one_select;
    powered |-> $onehot0({!o_boot_rom_select_n, !o_ram_select_n, o_card1_select, o_card2_select});
  endproperty
  a_one_select: assert property (p_one_select) else $error("two selects at once");
  property p_rom_no_write;
    powered && !o_write_strobe_n |-> o_boot_rom_select_n;
  endproperty
  a_rom_no_write: assert property (p_rom_no_write) else $error("rom write cycle");
  property p_write_drives;
    powered && !o_write_strobe_n |-> o_mem_byte_lines_oe;
  endproperty
  a_write_drives: assert property (p_write_drives) else $error("write without data");
  property p_poll_wait;
    poll |-> o_wait;
  endproperty
  a_poll_wait: assert property (p_poll_wait) else $error("poll without wait");
  property p_poll_lines;
    poll |-> o_mem_byte_addr_oe[17:9] == 9'h1FF && o_boot_rom_select_n && o_ram_select_n
             && !o_card1_select && !o_card2_select;
  endproperty
  a_poll_lines: assert property (p_poll_lines) else $error("poll line use wrong");
  property p_power_off;
    off_q >= 4'h8 |-> o_mem_byte_addr == 18'h00000 && o_mem_byte_lines == 8'h00
                      && !o_boot_rom_select_n && !o_ram_select_n && !o_write_strobe_n;
  endproperty
  a_power_off: assert property (p_power_off) else $error("outputs not low");
  property p_on_key;
    o_on_key_nmi |-> o_wake_request ##1 !o_on_key_nmi;
  endproperty
  a_on_key: assert property (p_on_key) else $error("on key pulse wrong");
  property p_beeper;
    i_out_reg_we |=> o_beeper_pad == $past(i_out_reg_data[11]);
  endproperty
  a_beeper: assert property (p_beeper) else $error("beeper late");
  property p_poll_on_read;
    $rose(i_in_reg_read) && !o_wait && !i_req && powered |-> ##[1:8] poll;
  endproperty
  a_poll_on_read: assert property (p_poll_on_read) else $error("no poll on read");
  property p_ack;
    o_ack |-> !o_wait ##1 !o_ack;
  endproperty
  a_ack: assert property (p_ack) else $error("ack shape wrong");
endmodule : nbmc_checker

bind nibble_bus_memory_controller nbmc_checker nbmc_checker_inst (.*);

// File: nbmc_mem_model.sv
`timescale 1ns/1ps
module nbmc_mem_model #(
  parameter int DELAY = 2
) (
  input  wire logic        i_clk,
  input  wire logic        i_power,
  input  wire logic [17:0] i_addr,
  input  wire logic [7:0]  i_data,
  input  wire logic        i_rom_n,
  input  wire logic        i_ram_n,
  input  wire logic        i_extra_n,
  input  wire logic        i_card1,
  input  wire logic        i_card2,
  input  wire logic        i_we_n,
  output logic [7:0]       o_data
);
  logic [7:0] mem_q [0:2047];
  logic [7:0] last_q = 8'h00;
  logic [4:0] age_q  = 5'h00;
  logic [2:0] dev;
  always_comb begin
    if (!i_ram_n) dev = 3'h1;
    else if (i_card1) dev = 3'h3;
    else if (i_card2) dev = 3'h4;
    else if (!i_rom_n) dev = 3'h0;
    else if (!i_extra_n) dev = 3'h2;
    else dev = 3'h7;
  end
  // Valid only after the access time; else a pattern that keeps changing
  assign o_data = (i_power && dev != 3'h7 && i_we_n && age_q >= 5'(DELAY)) ?
                  mem_q[{dev, i_addr[7:0]}] : ~last_q;
  always @(posedge i_clk) begin
    last_q <= o_data;
    if (!i_power || dev == 3'h7) age_q <= 5'h00;
    else if (age_q != 5'h1F) age_q <= age_q + 5'h01;
    if (i_power && dev != 3'h7 && !i_we_n) mem_q[{dev, i_addr[7:0]}] <= i_data;
  end
endmodule : nbmc_mem_model

// File: testbench.sv
`timescale 1ns/1ps
module testbench;
  import nbmc_pkg::*;
  logic        i_clk = 1'b0;
  logic        i_rst, i_bus_reset, i_cfg_valid, i_req, i_we, i_rom_redirect_debug_mode;
  logic        i_timer_bit2, i_in_reg_read, i_out_reg_we, i_on_key_line, i_card_power_rail;
  logic [2:0]  i_cfg_id;
  logic [19:0] i_cfg_data, i_addr, o_ext_addr;
  logic [3:0]  i_wdata, i_ext_nibble, o_rdata, o_ext_wdata, rd;
  logic [11:0] i_out_reg_data;
  logic [1:0]  i_card_write_ok, i_card_detect;
  logic [8:0]  i_key_sense_lines, o_key_sense_lines, key_val;
  logic [7:0]  i_mem_byte_lines, o_mem_byte_lines, mem_drv;
  logic [17:0] o_mem_byte_addr, o_mem_byte_addr_oe;
  logic        o_ack, o_wait, o_ext_select, o_ext_we, o_beeper_pad, o_on_key_nmi;
  logic        o_wake_request, o_mem_byte_lines_oe, o_boot_rom_select_n, o_ram_select_n;
  logic        o_extra_select_n, o_card1_select, o_card2_select, o_write_strobe_n;
  logic        saw_wait, saw_ext;
  logic [4:0]  sels;
  int          num_errors = 0;
  int          n_compared = 0;

  nibble_bus_memory_controller nibble_bus_memory_controller_inst (.*);
  nbmc_mem_model #(.DELAY(12)) nbmc_mem_model_inst (
    .i_clk(i_clk), .i_power(i_card_power_rail), .i_addr(o_mem_byte_addr),
    .i_data(o_mem_byte_lines), .i_rom_n(o_boot_rom_select_n), .i_ram_n(o_ram_select_n),
    .i_extra_n(o_extra_select_n), .i_card1(o_card1_select), .i_card2(o_card2_select),
    .i_we_n(o_write_strobe_n), .o_data(mem_drv)
  );
  // Wire level from both drivers
  assign i_mem_byte_lines  = o_mem_byte_lines_oe ? o_mem_byte_lines : mem_drv;
  assign i_key_sense_lines = (o_mem_byte_addr_oe[8:0] & o_mem_byte_addr[8:0])
                           | (~o_mem_byte_addr_oe[8:0] & key_val);
  always #5 i_clk = ~i_clk;

  function automatic logic [10:0] ix(input logic [2:0] d, input logic [19:0] a);
    return {d, a[8:1]};
  endfunction : ix
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic finish_test;
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : finish_test
  task automatic cfg(input logic [2:0] id, input logic [19:0] d);
    @(negedge i_clk);
    {i_cfg_valid, i_cfg_id, i_cfg_data} = {1'b1, id, d};
    @(negedge i_clk);
    i_cfg_valid = 1'b0;
  endtask : cfg
  task automatic access(input logic we, input logic [19:0] a, input logic [3:0] d);
    int n;
    n = 0;
    {saw_wait, saw_ext, sels} = '0;
    @(negedge i_clk);
    {i_req, i_we, i_addr, i_wdata} = {1'b1, we, a, d};
    do begin
      @(posedge i_clk);
      #1;
      n++;
      saw_wait |= o_wait;
      saw_ext |= o_ext_select;
      sels |= {o_card2_select, o_card1_select, !o_extra_select_n, !o_ram_select_n,
               !o_boot_rom_select_n};
    end while (o_ack !== 1'b1 && n < 300);
    rd = o_rdata;
    @(negedge i_clk);
    i_req = 1'b0;
    chk(20'(n < 300), 20'h1);
  endtask : access
  task automatic poll_watch(output logic [8:0] drv, output logic ok);
    logic seen;
    {seen, drv} = '0;
    ok = 1'b1;
    for (int n = 0; n < 400 && !(seen && o_mem_byte_addr_oe[8:0] != 9'h000); n++) begin
      @(posedge i_clk);
      #1;
      if (o_mem_byte_addr_oe[8:0] == 9'h000) begin
        seen = 1'b1;
        drv = o_mem_byte_addr[17:9];
        ok &= o_wait;
      end
    end
    ok &= seen;
  endtask : poll_watch

  task automatic t_boot;
    nbmc_mem_model_inst.mem_q[ix(3'h0, 20'h00011)] = 8'h4B;
    access(1'b0, 20'h00011, 4'h0);
    chk(20'({sels, rd}), 20'({5'h01, 4'h4}));
  endtask : t_boot
  task automatic t_ram;
    cfg(CFG_RAM, 20'hFF000);
    cfg(CFG_RAM, 20'h20000);
    nbmc_mem_model_inst.mem_q[ix(3'h1, 20'h20014)] = 8'h3C;
    access(1'b1, 20'h20010, 4'h5);
    chk(20'(sels), 20'h02);
    access(1'b1, 20'h20011, 4'hA);
    chk(20'(nbmc_mem_model_inst.mem_q[ix(3'h1, 20'h20010)]), 20'hA5);
    access(1'b1, 20'h20014, 4'h7);
    chk(20'(nbmc_mem_model_inst.mem_q[ix(3'h1, 20'h20014)]), 20'h37);
    access(1'b0, 20'h20015, 4'h0);
    chk(20'(rd), 20'h3);
  endtask : t_ram
  task automatic t_priority;
    cfg(CFG_CARD2, 20'hF0000);
    cfg(CFG_CARD2, 20'h20000);
    cfg(CFG_CARD1, 20'hFF000);
    cfg(CFG_CARD1, 20'h21000);
    cfg(CFG_EXTRA, 20'hFF000);
    cfg(CFG_EXTRA, 20'h60000);
    access(1'b0, 20'h20012, 4'h0);
    chk(20'(sels), 20'h02);
    access(1'b0, 20'h21002, 4'h0);
    chk(20'(sels), 20'h10);
    access(1'b0, 20'h2F000, 4'h0);
    chk(20'(sels), 20'h10);
    access(1'b0, 20'h60000, 4'h0);
    chk(20'(sels), 20'h04);
  endtask : t_priority
  task automatic t_refuse;
    i_card_write_ok = 2'b01;
    nbmc_mem_model_inst.mem_q[ix(3'h4, 20'h2F000)] = 8'h11;
    nbmc_mem_model_inst.mem_q[ix(3'h0, 20'h50000)] = 8'h22;
    repeat (8) @(negedge i_clk);
    access(1'b1, 20'h2F000, 4'hF);
    chk(20'({saw_wait, nbmc_mem_model_inst.mem_q[ix(3'h4, 20'h2F000)]}), 20'h011);
    access(1'b1, 20'h50000, 4'hF);
    chk(20'({saw_wait, nbmc_mem_model_inst.mem_q[ix(3'h0, 20'h50000)]}), 20'h022);
    i_card_write_ok = 2'b11;
  endtask : t_refuse
  task automatic t_ctrl_ext;
    {i_card_detect, i_ext_nibble} = {2'b01, 4'h6};
    cfg(CFG_CTRL, 20'h20100);
    repeat (8) @(negedge i_clk);
    access(1'b0, 20'h2010F, 4'h0);
    chk(20'({sels, rd}), 20'({5'h00, 4'hD}));
    access(1'b1, 20'h20129, 4'h8);
    access(1'b0, 20'h90000, 4'h0);
    chk(20'(sels), 20'h05);
    access(1'b0, 20'h10000, 4'h0);
    chk(20'(sels), 20'h01);
    access(1'b0, 20'h60000, 4'h0);
    chk(20'({saw_ext, rd}), 20'h16);
    i_rom_redirect_debug_mode = 1'b1;
    access(1'b0, 20'h50000, 4'h0);
    chk(20'({saw_ext, rd}), 20'h16);
    chk(o_ext_addr, 20'h50000);
    i_rom_redirect_debug_mode = 1'b0;
  endtask : t_ctrl_ext
  task automatic t_key_poll;
    logic [8:0] drv;
    logic       ok;
    key_val = 9'h0A5;
    @(negedge i_clk);
    {i_out_reg_we, i_out_reg_data} = {1'b1, 12'h955};
    @(negedge i_clk);
    {i_out_reg_we, i_in_reg_read} = 2'b01;
    chk(20'(o_beeper_pad), 20'h1);
    @(negedge i_clk);
    i_in_reg_read = 1'b0;
    poll_watch(drv, ok);
    chk(20'({ok, drv, o_key_sense_lines}), 20'({1'b1, 9'h155, 9'h0A5}));
    @(negedge i_clk);
    {key_val, i_timer_bit2} = {9'h13C, 1'b1};
    poll_watch(drv, ok);
    chk(20'({ok, o_key_sense_lines}), 20'({1'b1, 9'h13C}));
    @(negedge i_clk);
    i_timer_bit2 = 1'b0;
  endtask : t_key_poll
  task automatic t_on_key;
    int hits;
    hits = 0;
    @(negedge i_clk);
    i_on_key_line = 1'b1;
    repeat (20) begin
      @(posedge i_clk);
      #1;
      hits += int'(o_on_key_nmi);
    end
    @(negedge i_clk);
    i_on_key_line = 1'b0;
    chk(20'(hits), 20'h1);
  endtask : t_on_key
  task automatic t_power_off;
    @(negedge i_clk);
    i_card_power_rail = 1'b0;
    repeat (12) @(negedge i_clk);
    chk(20'({o_mem_byte_addr, o_boot_rom_select_n, o_write_strobe_n}), 20'h0);
    i_card_power_rail = 1'b1;
    repeat (10) @(negedge i_clk);
  endtask : t_power_off
  task automatic t_bus_reset;
    @(negedge i_clk);
    i_bus_reset = 1'b1;
    @(negedge i_clk);
    i_bus_reset = 1'b0;
    access(1'b0, 20'h20010, 4'h0);
    chk(20'({sels, rd}), 20'({5'h01, 4'hB}));
  endtask : t_bus_reset

  initial begin
    {i_bus_reset, i_cfg_valid, i_req, i_we, i_rom_redirect_debug_mode, i_timer_bit2,
     i_in_reg_read, i_out_reg_we, i_on_key_line, i_cfg_id, i_cfg_data, i_addr, i_wdata,
     i_ext_nibble, i_out_reg_data, i_card_detect, key_val} = '0;
    {i_rst, i_card_power_rail, i_card_write_ok} = 4'hF;
    repeat (8) @(posedge i_clk);
    @(negedge i_clk);
    i_rst = 1'b0;
    repeat (8) @(negedge i_clk);
    t_boot();
    t_ram();
    t_priority();
    t_refuse();
    t_ctrl_ext();
    t_key_poll();
    t_on_key();
    t_power_off();
    t_bus_reset();
    finish_test();
  end
  // Run needs under a thousand cycles
  initial begin
    #200000;
    num_errors++;
    finish_test();
  end
endmodule : testbench
